// ===== aav_access_virtualizer.sv
// Purpose: Priority-register shadowing and access-page read filtering.
// Assumes: All inputs synchronous to clk_i; one memory access in flight.
// Notes:   Write virtualization is not handled; every page write exits.
//
// Our own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Shadowed priority read returns virtual priority bits 7:4 in bits 3:0, rest zero.
// - Shadowed priority write puts source 3:0 in bits 7:4, clears rest, virtualizes.
// - Without shadowing, priority register reads and writes reach the real controller.
// - No virtual interrupt recognized or delivered while interrupt-window exiting is set.
// - After virtualization, delivery off and class below threshold gives a trap-like exit.
// - With access virtualization on, accesses to the 4-KByte page exit by default.
// - Page match uses the final physical address, never the guest-physical one.
// - A page fault or nested violation is taken instead of an access-page exit.
// - Accessed flags in all paging structures are set before the exit.
// - For writes, dirty flags are set as well before the exit.
// - The access-page exit ranks with the fault that access could cause.
// - Earlier string iterations complete; exit points at the string instruction.
// - An operation is one string iteration, one instruction or one event delivery.
// - Reads exit when shadowing is off, on fetch, above 32 bits, or after a write.
// - Reads exit unless first and last bytes have address bits 3:2 zero.
// - Without register virtualization only offset 080H reads are virtualized.
// - Register virtualization adds identifier, version, end-of-interrupt, destination, format and spurious slots.
// - Register virtualization adds in-service, trigger-mode and request slots.
// - Register virtualization adds error, command, vector, count and divide slots.
// - Any other read of the page exits.
// - A virtualized read returns the virtual page data at the same offset.
module aav_access_virtualizer
	import aav_pkg::*;
#(
	parameter int PA_W = 52
) (
	// Clock and reset
	input  wire logic              clk_i,
	input  wire logic              sys_rst_i,
	// Execution controls
	input  wire logic              shadow_priority_enable_i,
	input  wire logic              access_page_virt_enable_i,
	input  wire logic              register_virt_enable_i,
	input  wire logic              virt_intr_delivery_i,
	input  wire logic              intr_window_exit_i,
	input  wire logic [3:0]        priority_threshold_i,
	input  wire logic [PA_W-1:0]   access_page_addr_i,
	// Priority control register instructions
	input  wire logic              prio_rd_i,
	input  wire logic              prio_wr_i,
	input  wire logic [63:0]       prio_wdata_i,
	output logic                   prio_rvalid_o,
	output logic [63:0]            prio_rdata_o,
	output logic [31:0]            virtual_task_priority_o,
	output logic                   prio_below_exit_o,
	output logic                   eval_pending_o,
	// Real task-priority register
	output logic                   task_priority_rd_o,
	output logic                   task_priority_wr_o,
	output logic [3:0]             task_priority_wdata_o,
	input  wire logic [3:0]        task_priority_rdata_i,
	// Virtual interrupt recognition
	input  wire logic              virt_intr_pending_i,
	output logic                   virt_intr_deliver_o,
	// Operation boundaries
	input  wire logic              op_done_i,
	input  wire logic              op_write_virt_i,
	// Memory access
	input  wire logic              mem_req_i,
	input  wire logic [PA_W-1:0]   mem_phys_addr_i,
	input  wire logic [SIZE_W-1:0] mem_size_i,
	input  wire logic              mem_write_i,
	input  wire logic              mem_fetch_i,
	input  wire logic              page_fault_i,
	input  wire logic              nested_violation_i,
	output logic                   mem_busy_o,
	output logic                   mem_pass_o,
	output logic                   fault_o,
	// Paging flag update
	output logic                   flag_set_o,
	output logic                   flag_dirty_o,
	input  wire logic              flag_done_i,
	// Virtual controller page
	output logic                   vpage_rd_o,
	output logic [OFF_W-1:0]       vpage_offset_o,
	input  wire logic [31:0]       vpage_rdata_i,
	output logic                   rd_valid_o,
	output logic [31:0]            rd_data_o,
	// Access-page exit
	output logic                   exit_o,
	output logic [OFF_W-1:0]       exit_offset_o,
	output logic                   exit_write_o,
	output logic                   exit_fetch_o,
	output logic [ITER_W-1:0]      exit_iter_o
);

	// Page number must leave room above the 4-KByte offset
	if (PA_W <= PAGE_SHIFT || PA_W > 64) begin : g_pa_w_check
		$error("PA_W out of range");
	end

	// Slot is page offset bits 11:4, one 16-byte register slot each
	function automatic logic slot_virt(input logic [SLOT_W-1:0] slot, input logic regv);
		logic hit;
		hit = (slot == SLOT_PRIORITY);
		if (regv) begin
			hit = hit || slot == SLOT_ID || slot == SLOT_VERSION || slot == SLOT_EOI
				|| slot == SLOT_LOG_DEST || slot == SLOT_DEST_FMT
				|| slot == SLOT_SPURIOUS;
			hit = hit || (slot >= SLOT_ISR_FIRST && slot <= SLOT_IRR_LAST);
			hit = hit || slot == SLOT_ERR_STATUS || slot == SLOT_INIT_COUNT
				|| slot == SLOT_DIVIDE_CFG
				|| (slot >= SLOT_CMD_FIRST && slot <= SLOT_LVT_LAST);
		end
		return hit;
	endfunction

	// Priority path state
	logic [31:0]       vtp_reg, vtp_next;
	logic              prio_rvalid_reg, prio_rvalid_next;
	logic [63:0]       prio_rdata_reg, prio_rdata_next;
	logic              below_reg, below_next;
	logic              eval_reg, eval_next;
	logic              tp_rd_reg, tp_rd_next;
	logic              tp_wr_reg, tp_wr_next;
	logic [3:0]        tp_wdata_reg, tp_wdata_next;
	logic              tp_pend_reg, tp_pend_next;
	logic              deliver_reg, deliver_next;

	always_comb begin
		vtp_next         = vtp_reg;
		prio_rvalid_next = 1'b0;
		prio_rdata_next  = prio_rdata_reg;
		below_next       = 1'b0;
		eval_next        = 1'b0;
		tp_rd_next       = 1'b0;
		tp_wr_next       = 1'b0;
		tp_wdata_next    = tp_wdata_reg;
		tp_pend_next     = 1'b0;
		// Real register data returns one cycle after the read strobe
		if (tp_pend_reg) begin
			prio_rvalid_next = 1'b1;
			prio_rdata_next  = {60'h0, task_priority_rdata_i};
		end
		if (prio_rd_i) begin
			if (shadow_priority_enable_i) begin
				prio_rvalid_next = 1'b1;
				prio_rdata_next  = {60'h0, vtp_reg[VTP_CLASS_MSB:VTP_CLASS_LSB]};
			end else begin
				tp_rd_next   = 1'b1;
				tp_pend_next = 1'b1;
			end
		end else if (prio_wr_i) begin
			if (shadow_priority_enable_i) begin
				vtp_next = {24'h0, prio_wdata_i[3:0], 4'h0};
				// Trap-like: decided on the new value, after the write completes
				if (!virt_intr_delivery_i) begin
					below_next = (prio_wdata_i[3:0] < priority_threshold_i);
				end else begin
					eval_next = 1'b1;
				end
			end else begin
				tp_wr_next    = 1'b1;
				tp_wdata_next = prio_wdata_i[3:0];
			end
		end
		// Recognition is suppressed entirely while window exiting is set
		deliver_next = virt_intr_pending_i && !intr_window_exit_i
			&& virt_intr_delivery_i;
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			vtp_reg         <= VTP_RESET;
			prio_rvalid_reg <= 1'b0;
			prio_rdata_reg  <= 64'h0;
			below_reg       <= 1'b0;
			eval_reg        <= 1'b0;
			tp_rd_reg       <= 1'b0;
			tp_wr_reg       <= 1'b0;
			tp_wdata_reg    <= 4'h0;
			tp_pend_reg     <= 1'b0;
			deliver_reg     <= 1'b0;
		end else begin
			vtp_reg         <= vtp_next;
			prio_rvalid_reg <= prio_rvalid_next;
			prio_rdata_reg  <= prio_rdata_next;
			below_reg       <= below_next;
			eval_reg        <= eval_next;
			tp_rd_reg       <= tp_rd_next;
			tp_wr_reg       <= tp_wr_next;
			tp_wdata_reg    <= tp_wdata_next;
			tp_pend_reg     <= tp_pend_next;
			deliver_reg     <= deliver_next;
		end
	end

	assign virtual_task_priority_o = vtp_reg;
	assign prio_rvalid_o           = prio_rvalid_reg;
	assign prio_rdata_o            = prio_rdata_reg;
	assign prio_below_exit_o       = below_reg;
	assign eval_pending_o          = eval_reg;
	assign task_priority_rd_o      = tp_rd_reg;
	assign task_priority_wr_o      = tp_wr_reg;
	assign task_priority_wdata_o   = tp_wdata_reg;
	assign virt_intr_deliver_o     = deliver_reg;

	// Access path state
	aav_state_t        st_reg, st_next;
	logic [OFF_W-1:0]  off_reg, off_next;
	logic              wr_reg, wr_next;
	logic              fetch_reg, fetch_next;
	logic              virt_reg, virt_next;
	logic              opw_reg, opw_next;
	logic [ITER_W-1:0] iter_reg, iter_next;
	logic              pass_reg, pass_next;
	logic              fault_reg, fault_next;
	logic              flag_reg, flag_next;
	logic              vrd_reg, vrd_next;
	logic              rdv_reg, rdv_next;
	logic [31:0]       rdd_reg, rdd_next;
	logic              exit_reg, exit_next;
	logic              busy_reg, busy_next;

	logic              in_page;
	logic [OFF_W-1:0]  req_off;
	logic [OFF_W-1:0]  last_off;
	logic              read_ok;

	always_comb begin
		// Final physical address, whatever translation produced it
		in_page  = access_page_virt_enable_i
			&& mem_phys_addr_i[PA_W-1:PAGE_SHIFT]
			== access_page_addr_i[PA_W-1:PAGE_SHIFT];
		req_off  = mem_phys_addr_i[OFF_W-1:0];
		// Size 0 wraps below req_off; such reads exit by the size test anyway
		last_off = req_off + OFF_W'(mem_size_i) - 12'h001;
		read_ok  = shadow_priority_enable_i && !mem_fetch_i && !mem_write_i
			&& mem_size_i != 4'h0 && mem_size_i <= MAX_VIRT_BYTES
			&& !opw_reg && !op_write_virt_i;
		read_ok  = read_ok && req_off[3:2] == 2'b00 && last_off[3:2] == 2'b00
			&& req_off[OFF_W-1:4] == last_off[OFF_W-1:4];
		// Without register virtualization the offset must be exactly 080H
		read_ok  = read_ok && (register_virt_enable_i || req_off[1:0] == 2'b00);
		read_ok  = read_ok && slot_virt(req_off[OFF_W-1:4], register_virt_enable_i);
	end

	always_comb begin
		st_next    = st_reg;
		off_next   = off_reg;
		wr_next    = wr_reg;
		fetch_next = fetch_reg;
		virt_next  = virt_reg;
		// Write history lasts until the operation ends
		opw_next   = opw_reg || op_write_virt_i;
		iter_next  = iter_reg;
		pass_next  = 1'b0;
		fault_next = 1'b0;
		flag_next  = 1'b0;
		vrd_next   = 1'b0;
		rdv_next   = 1'b0;
		rdd_next   = rdd_reg;
		exit_next  = 1'b0;
		// Operation end clears per-operation history; one string step counts as one
		if (op_done_i) begin
			opw_next  = 1'b0;
			iter_next = iter_reg + 16'h0001;
		end
		case (st_reg)
			ST_IDLE: begin
				if (mem_req_i) begin
					off_next   = req_off;
					wr_next    = mem_write_i;
					fetch_next = mem_fetch_i;
					if (page_fault_i || nested_violation_i) begin
						fault_next = 1'b1;
					end else if (in_page) begin
						virt_next = read_ok;
						flag_next = 1'b1;
						st_next   = ST_FLAGS;
					end else begin
						pass_next = 1'b1;
					end
				end
			end
			ST_FLAGS: begin
				// Exit or redirect only once flags are in memory
				if (flag_done_i) begin
					st_next = virt_reg ? ST_VREAD : ST_EXIT;
				end
			end
			ST_VREAD: begin
				vrd_next = 1'b1;
				st_next  = ST_VDATA;
			end
			ST_VDATA: begin
				// Data is taken the cycle after the strobe drops
				if (!vrd_reg) begin
					rdv_next = 1'b1;
					rdd_next = vpage_rdata_i;
					st_next  = ST_IDLE;
				end
			end
			ST_EXIT: begin
				exit_next = 1'b1;
				st_next   = ST_IDLE;
			end
			default: begin
				st_next = ST_IDLE;
			end
		endcase
		// Count restarts after an exit; an operation ending in that cycle still counts
		if (exit_reg) begin
			iter_next = op_done_i ? 16'h0001 : 16'h0000;
		end
		// Registered so the busy output is a flop, with the timing of the state
		busy_next = (st_next != ST_IDLE);
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			st_reg    <= ST_IDLE;
			off_reg   <= 12'h000;
			wr_reg    <= 1'b0;
			fetch_reg <= 1'b0;
			virt_reg  <= 1'b0;
			opw_reg   <= 1'b0;
			iter_reg  <= 16'h0000;
			pass_reg  <= 1'b0;
			fault_reg <= 1'b0;
			flag_reg  <= 1'b0;
			vrd_reg   <= 1'b0;
			rdv_reg   <= 1'b0;
			rdd_reg   <= 32'h0000_0000;
			exit_reg  <= 1'b0;
			busy_reg  <= 1'b0;
		end else begin
			st_reg    <= st_next;
			off_reg   <= off_next;
			wr_reg    <= wr_next;
			fetch_reg <= fetch_next;
			virt_reg  <= virt_next;
			opw_reg   <= opw_next;
			iter_reg  <= iter_next;
			pass_reg  <= pass_next;
			fault_reg <= fault_next;
			flag_reg  <= flag_next;
			vrd_reg   <= vrd_next;
			rdv_reg   <= rdv_next;
			rdd_reg   <= rdd_next;
			exit_reg  <= exit_next;
			busy_reg  <= busy_next;
		end
	end

	assign mem_busy_o     = busy_reg;
	assign mem_pass_o     = pass_reg;
	assign fault_o        = fault_reg;
	assign flag_set_o     = flag_reg;
	assign flag_dirty_o   = wr_reg;
	assign vpage_rd_o     = vrd_reg;
	assign vpage_offset_o = off_reg;
	assign rd_valid_o     = rdv_reg;
	assign rd_data_o      = rdd_reg;
	assign exit_o         = exit_reg;
	assign exit_offset_o  = off_reg;
	assign exit_write_o   = wr_reg;
	assign exit_fetch_o   = fetch_reg;
	assign exit_iter_o    = iter_reg;

endmodule

`default_nettype wire

// ===== aav_access_virtualizer_asserts.sv
// Purpose: Port-level checks of the access virtualizer.
// Assumes: One clock; synchronous active-high reset.
// Notes:   Bound into every instance of the design.
`timescale 1ns/1ps
`default_nettype none
module aav_access_virtualizer_asserts
	import aav_pkg::*;
#(
	parameter int PA_W = 52
) (
	// Clock, reset and controls
	input wire logic            clk_i,
	input wire logic            sys_rst_i,
	input wire logic            shadow_priority_enable_i,
	input wire logic            access_page_virt_enable_i,
	input wire logic            intr_window_exit_i,
	input wire logic [PA_W-1:0] access_page_addr_i,
	// Priority path
	input wire logic            prio_rd_i,
	input wire logic            prio_wr_i,
	input wire logic [63:0]     prio_wdata_i,
	input wire logic            prio_rvalid_o,
	input wire logic [63:0]     prio_rdata_o,
	input wire logic [31:0]     virtual_task_priority_o,
	input wire logic            task_priority_rd_o,
	input wire logic            virt_intr_deliver_o,
	// Memory path
	input wire logic            mem_req_i,
	input wire logic [PA_W-1:0] mem_phys_addr_i,
	input wire logic            mem_write_i,
	input wire logic            mem_fetch_i,
	input wire logic            page_fault_i,
	input wire logic            nested_violation_i,
	input wire logic            mem_busy_o,
	input wire logic            fault_o,
	input wire logic            flag_set_o,
	input wire logic            flag_dirty_o,
	input wire logic            flag_done_i,
	input wire logic            vpage_rd_o,
	input wire logic [OFF_W-1:0] vpage_offset_o,
	input wire logic            rd_valid_o,
	input wire logic            exit_o,
	input wire logic            exit_fetch_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	// Fault-free request that lands on the access page
	sequence s_page_req;
		mem_req_i && !mem_busy_o && access_page_virt_enable_i && !page_fault_i && !nested_violation_i
		&& (mem_phys_addr_i[PA_W-1:12] == access_page_addr_i[PA_W-1:12]);
	endsequence
	chk_shadow_read: assert property (
		prio_rd_i && shadow_priority_enable_i |=> prio_rvalid_o
		&& prio_rdata_o == {60'h0, virtual_task_priority_o[7:4]}) else $error("shadow read wrong");
	chk_shadow_write: assert property (
		prio_wr_i && !prio_rd_i && shadow_priority_enable_i
		|=> virtual_task_priority_o == {24'h0, $past(prio_wdata_i[3:0]), 4'h0})
		else $error("shadow write wrong");
	chk_real_read: assert property (
		prio_rd_i && !shadow_priority_enable_i |=> task_priority_rd_o ##1 prio_rvalid_o)
		else $error("real read not issued");
	chk_window_block: assert property (
		intr_window_exit_i |=> !virt_intr_deliver_o) else $error("delivery during window");
	chk_fault_first: assert property (
		mem_req_i && !mem_busy_o && (page_fault_i || nested_violation_i)
		|=> fault_o && !flag_set_o && !exit_o) else $error("fault not taken");
	chk_flags_before_exit: assert property (
		exit_o |-> $past(flag_done_i, 2)) else $error("exit before flags");
	chk_dirty_flag: assert property (
		flag_set_o |-> flag_dirty_o == $past(mem_write_i)) else $error("dirty flag wrong");
	chk_page_flag: assert property (
		s_page_req |=> flag_set_o) else $error("page hit missed");
	chk_fetch_exit: assert property (
		s_page_req ##0 mem_fetch_i |-> ##[2:20] (exit_o && exit_fetch_o)) else $error("fetch no exit");
	chk_vread_align: assert property (
		vpage_rd_o |-> (vpage_offset_o[3:2] == 2'h0) ##2 rd_valid_o) else $error("bad virtual read");
endmodule
bind aav_access_virtualizer aav_access_virtualizer_asserts #(.PA_W(PA_W)) u_aav_access_virtualizer_asserts (.*);
`default_nettype wire

// ===== aav_access_virtualizer_test.sv
// Purpose: Self-checking bench for the access virtualizer.
// Assumes: Guest model answers flag updates and page reads.
// Notes:   Slot sweep plus random reads over sizes, controls and stalls.
`timescale 1ns/1ps
`default_nettype none
module aav_access_virtualizer_test;
	import aav_pkg::*;
	localparam logic [51:0] PAGE = 52'h0_0000_1234_5000;
	logic clk_i = 1'b0, sys_rst_i = 1'b1, slow = 1'b0;
	logic shadow_priority_enable_i = 1'b1, access_page_virt_enable_i = 1'b1;
	logic register_virt_enable_i = 1'b0, virt_intr_delivery_i = 1'b0, intr_window_exit_i = 1'b0;
	logic [3:0] priority_threshold_i = 4'h0, mem_size_i = 4'h0, task_priority_rdata_i;
	logic [51:0] access_page_addr_i = PAGE, mem_phys_addr_i = 52'h0;
	logic prio_rd_i = 1'b0, prio_wr_i = 1'b0, virt_intr_pending_i = 1'b0;
	logic [63:0] prio_wdata_i = 64'h0, prio_rdata_o;
	logic op_done_i = 1'b0, op_write_virt_i = 1'b0, mem_req_i = 1'b0, mem_write_i = 1'b0;
	logic mem_fetch_i = 1'b0, page_fault_i = 1'b0, nested_violation_i = 1'b0, flag_done_i;
	logic [31:0] vpage_rdata_i, virtual_task_priority_o, rd_data_o;
	logic prio_rvalid_o, prio_below_exit_o, eval_pending_o, task_priority_rd_o, task_priority_wr_o;
	logic virt_intr_deliver_o, mem_busy_o, mem_pass_o, fault_o, flag_set_o, flag_dirty_o;
	logic vpage_rd_o, rd_valid_o, exit_o, exit_write_o, exit_fetch_o;
	logic [3:0] task_priority_wdata_o;
	logic [11:0] vpage_offset_o, exit_offset_o;
	logic [15:0] exit_iter_o;
	logic [31:0] seed = 32'd44839, v;
	int fails = 0, tests_run = 0, cyc = 0, i;
	aav_access_virtualizer u_aav_access_virtualizer (.*);
	aav_guest_model u_aav_guest_model (.clk_i, .sys_rst_i, .slow_i(slow),
		.flag_set_i(flag_set_o), .flag_done_o(flag_done_i), .vpage_rd_i(vpage_rd_o),
		.vpage_offset_i(vpage_offset_o), .vpage_rdata_o(vpage_rdata_i),
		.task_priority_rd_i(task_priority_rd_o), .task_priority_wr_i(task_priority_wr_o),
		.task_priority_wdata_i(task_priority_wdata_o), .task_priority_rdata_o(task_priority_rdata_i));
	always #12.5 clk_i = ~clk_i;
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// Expected outcome of a plain read: 2 exit, 3 virtualized
	function automatic logic [2:0] expect_oc(input logic [11:0] off, input logic [3:0] sz);
		logic [4:0] top;
		top = {3'h0, off[1:0]} + {1'b0, sz} - 5'h1;
		if (!shadow_priority_enable_i || sz == 4'h0 || sz > 4'h4 || off[3:2] != 2'h0 || top[4:2] != 3'h0)
			return 3'h2;
		if (!register_virt_enable_i)
			return (off == 12'h080) ? 3'h3 : 3'h2;
		return (off[11:4] inside {8'h02, 8'h03, 8'h08, 8'h0B, 8'h0D, 8'h0E, 8'h0F, [8'h10:8'h28],
			[8'h30:8'h38], 8'h3E}) ? 3'h3 : 3'h2;
	endfunction
	task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fails++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic report_and_stop();
		if (fails == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic prio(input logic rd, input logic [63:0] d);
		@(posedge clk_i);
		prio_rd_i <= rd;
		prio_wr_i <= !rd;
		prio_wdata_i <= d;
		@(posedge clk_i);
		prio_rd_i <= 1'b0;
		prio_wr_i <= 1'b0;
		#1;
	endtask
	task automatic pulse(input logic wv);
		@(posedge clk_i);
		op_done_i <= !wv;
		op_write_virt_i <= wv;
		@(posedge clk_i);
		op_done_i <= 1'b0;
		op_write_virt_i <= 1'b0;
	endtask
	// k = {nested, page fault, fetch, write}; out moves the access off the page
	task automatic mexp(input logic [11:0] off, input logic [3:0] sz, input logic [3:0] k,
		input logic out, input logic [2:0] e);
		logic [2:0] oc;
		@(posedge clk_i);
		mem_req_i <= 1'b1;
		mem_phys_addr_i <= {PAGE[51:12] ^ {39'h0, out}, off};
		mem_size_i <= sz;
		{nested_violation_i, page_fault_i, mem_fetch_i, mem_write_i} <= k;
		@(posedge clk_i);
		mem_req_i <= 1'b0;
		oc = 3'h7;
		for (int n = 0; n < 30 && oc == 3'h7; n++) begin
			#1;
			oc = mem_pass_o ? 3'h0 : fault_o ? 3'h1 : exit_o ? 3'h2 : rd_valid_o ? 3'h3 : 3'h7;
			if (oc == 3'h7)
				@(posedge clk_i);
		end
		chk("outcome", oc, e);
		if (e == 3'h2)
			chk("exit offset and kind", {exit_offset_o, exit_write_o}, {off, k[0]});
		if (e == 3'h3)
			chk("virtual read data", rd_data_o, {16'hA5A5, 4'h0, off});
	endtask
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			report_and_stop();
		end
	end
	initial begin
		repeat (10) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		for (i = 0; i < 16; i++) begin
			v = rnd();
			virt_intr_delivery_i <= v[8];
			priority_threshold_i <= v[7:4];
			prio(1'b0, {rnd(), v});
			chk("below threshold", prio_below_exit_o, !v[8] && v[3:0] < v[7:4]);
			chk("evaluation", eval_pending_o, v[8]);
			chk("virtual priority", virtual_task_priority_o, {24'h0, v[3:0], 4'h0});
			prio(1'b1, 64'h0);
			chk("shadow read", {prio_rvalid_o, prio_rdata_o}, {1'b1, 60'h0, v[3:0]});
		end
		shadow_priority_enable_i <= 1'b0;
		prio(1'b0, 64'hFFFF_FFFF_FFFF_FFFB);
		chk("real write", {task_priority_wr_o, task_priority_wdata_o}, 5'h1B);
		prio(1'b1, 64'h0);
		chk("real read strobe", task_priority_rd_o, 1'b1);
		@(posedge clk_i);
		#1;
		chk("real read", {prio_rvalid_o, prio_rdata_o}, {1'b1, 64'hB});
		mexp(12'h080, 4'h4, 4'h0, 1'b0, 3'h2);
		shadow_priority_enable_i <= 1'b1;
		virt_intr_pending_i <= 1'b1;
		virt_intr_delivery_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		#1;
		chk("delivery", virt_intr_deliver_o, 1'b1);
		intr_window_exit_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		#1;
		chk("delivery in window", virt_intr_deliver_o, 1'b0);
		mexp(12'h080, 4'h4, 4'h0, 1'b1, 3'h0);
		mexp(12'h080, 4'h4, 4'h4, 1'b0, 3'h1);
		mexp(12'h080, 4'h4, 4'h8, 1'b0, 3'h1);
		mexp(12'h080, 4'h4, 4'h1, 1'b0, 3'h2);
		mexp(12'h080, 4'h4, 4'h2, 1'b0, 3'h2);
		mexp(12'h080, 4'h8, 4'h0, 1'b0, 3'h2);
		mexp(12'h082, 4'h4, 4'h0, 1'b0, 3'h2);
		mexp(12'h08C, 4'h4, 4'h0, 1'b0, 3'h2);
		repeat (3) pulse(1'b0);
		mexp(12'h020, 4'h4, 4'h0, 1'b0, 3'h2);
		chk("iterations at exit", exit_iter_o, 16'h3);
		pulse(1'b1);
		mexp(12'h080, 4'h4, 4'h0, 1'b0, 3'h2);
		pulse(1'b0);
		mexp(12'h080, 4'h4, 4'h0, 1'b0, 3'h3);
		mexp(12'h081, 4'h1, 4'h0, 1'b0, 3'h2);
		for (i = 0; i < 128; i++) begin
			register_virt_enable_i <= i[6];
			#1;
			mexp({i[5:0], 6'h0} >> 2, 4'h4, 4'h0, 1'b0, expect_oc({i[5:0], 6'h0} >> 2, 4'h4));
		end
		for (i = 0; i < 80; i++) begin
			v = rnd();
			register_virt_enable_i <= v[10];
			slow <= v[11];
			#1;
			mexp({2'h0, v[5:0], v[8] & v[9], 1'b0, v[7:6]}, {1'b0, v[14:12]} + 4'h1, 4'h0, 1'b0,
				expect_oc({2'h0, v[5:0], v[8] & v[9], 1'b0, v[7:6]}, {1'b0, v[14:12]} + 4'h1));
		end
		report_and_stop();
	end
endmodule
`default_nettype wire

// ===== aav_guest_model.sv
// Purpose: Far side: paging flag walker, virtual page and real priority register.
// Assumes: Read data valid while the strobe is high and one cycle after.
// Notes:   Outside that window the data lines show the inverse, never stale data.
`timescale 1ns/1ps
`default_nettype none
module aav_guest_model (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        sys_rst_i,
	input  wire logic        slow_i,
	// Flag walker and virtual page
	input  wire logic        flag_set_i,
	output logic             flag_done_o,
	input  wire logic        vpage_rd_i,
	input  wire logic [11:0] vpage_offset_i,
	output logic [31:0]      vpage_rdata_o,
	// Real priority register
	input  wire logic        task_priority_rd_i,
	input  wire logic        task_priority_wr_i,
	input  wire logic [3:0]  task_priority_wdata_i,
	output logic [3:0]       task_priority_rdata_o
);
	logic [2:0] wait_reg, wait_next;
	logic [3:0] tpr_reg, tpr_next;
	logic       vld_reg, tvld_reg;
	logic [31:0] vdata;
	always_comb begin
		wait_next = wait_reg;
		if (flag_set_i)
			wait_next = slow_i ? 3'h4 : 3'h1;
		else if (wait_reg != 3'h0)
			wait_next = wait_reg - 3'h1;
		tpr_next = task_priority_wr_i ? task_priority_wdata_i : tpr_reg;
	end
	always_ff @(posedge clk_i) begin
		wait_reg <= sys_rst_i ? 3'h0 : wait_next;
		tpr_reg <= sys_rst_i ? 4'h0 : tpr_next;
		vld_reg <= vpage_rd_i;
		tvld_reg <= task_priority_rd_i;
	end
	assign flag_done_o = (wait_reg == 3'h1);
	assign vdata = {16'hA5A5, 4'h0, vpage_offset_i};
	assign vpage_rdata_o = (vpage_rd_i || vld_reg) ? vdata : ~vdata;
	assign task_priority_rdata_o = (task_priority_rd_i || tvld_reg) ? tpr_reg : ~tpr_reg;
endmodule
`default_nettype wire

// ===== aav_pkg.sv
// Purpose: Shared constants for the interrupt-controller access virtualizer.
// Assumes: Byte-granular page offsets inside a 4-KByte access page.
// Notes:   Slot numbers are page offset bits 11:4 (one 16-byte slot each).
package aav_pkg;

	localparam int          PAGE_SHIFT      = 12;
	localparam int          OFF_W           = 12;
	localparam int          SLOT_W          = 8;
	localparam int          SIZE_W          = 4;
	localparam int          ITER_W          = 16;
	localparam logic [3:0]  MAX_VIRT_BYTES  = 4'h4;

	// Slot numbers of virtualizable registers
	localparam logic [7:0]  SLOT_ID         = 8'h02;
	localparam logic [7:0]  SLOT_VERSION    = 8'h03;
	localparam logic [7:0]  SLOT_PRIORITY   = 8'h08;
	localparam logic [7:0]  SLOT_EOI        = 8'h0B;
	localparam logic [7:0]  SLOT_LOG_DEST   = 8'h0D;
	localparam logic [7:0]  SLOT_DEST_FMT   = 8'h0E;
	localparam logic [7:0]  SLOT_SPURIOUS   = 8'h0F;
	localparam logic [7:0]  SLOT_ISR_FIRST  = 8'h10;
	localparam logic [7:0]  SLOT_IRR_LAST   = 8'h27;
	localparam logic [7:0]  SLOT_ERR_STATUS = 8'h28;
	localparam logic [7:0]  SLOT_CMD_FIRST  = 8'h30;
	localparam logic [7:0]  SLOT_LVT_LAST   = 8'h37;
	localparam logic [7:0]  SLOT_INIT_COUNT = 8'h38;
	localparam logic [7:0]  SLOT_DIVIDE_CFG = 8'h3E;

	// Virtual task-priority field layout
	localparam int          VTP_CLASS_LSB   = 4;
	localparam int          VTP_CLASS_MSB   = 7;
	localparam logic [31:0] VTP_RESET       = 32'h0000_0000;

	typedef enum logic [4:0] {
		ST_IDLE  = 5'b00001,
		ST_FLAGS = 5'b00010,
		ST_VREAD = 5'b00100,
		ST_VDATA = 5'b01000,
		ST_EXIT  = 5'b10000
	} aav_state_t;

endpackage
